// ### design/irq_ctrl_params.svh
// Purpose: constants for the cpu interrupt controller
// Assumes: included by the edge detector and the controller only
// Notes: vector n sits two bytes below vector n-1
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
// fixed vector addresses (high byte address of each pair is +1)
`define VEC_RESET 16'hfffe
`define VEC_TRAP 16'hfffc
`define VEC_BASE 16'hfffa
// vector number count and slot maps
`define NUM_VECTORS 14
`define VEC_USED_MASK 14'h085f
`define HALT_WAKE_MASK 14'h0003
// condition code bit that masks interrupts
`define MASK_BIT_POS 3
// context bytes moved on entry and return
`define CTX_LAST 3'h4
// external sensitivity encodings
`define SENS_FALL_LOW 2'h0
`define SENS_RISE 2'h1
`define SENS_FALL 2'h2
`define SENS_BOTH 2'h3
`endif

// ### design/irq_ctrl_pkg.sv
// Purpose: shared types of the cpu interrupt controller
// Assumes: nothing
// Notes: constants live in irq_ctrl_params.svh
package irq_ctrl_pkg;
  // sequencer states, gray along idle-push-vector and idle-pop
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PUSH = 3'h1,
    ST_VEC = 3'h3,
    ST_POP = 3'h2
  } ctrl_state_t;
  // core power state
  typedef enum logic [1:0] {
    LP_RUN = 2'h0,
    LP_WAIT = 2'h1,
    LP_HALT = 2'h2
  } power_t;
  // external sensitivity selection
  typedef logic [1:0] sens_t;
endpackage : irq_ctrl_pkg

// ### design/irq_src_if.sv
// Purpose: one interrupt source between the controller and its request latch
// Assumes: single clock
// Notes: pend is the raw latch, req is the gated request
`timescale 1ns/1ps
interface irq_src_if;
  logic trig; // source level or flag
  logic en; // source enable
  logic clr; // latch clear pulse
  logic pend; // latched request
  logic req; // enabled request
  modport ctrl (output trig, output en, output clr, input pend, input req);
  modport latch (input trig, input en, input clr, output pend, output req);
endinterface : irq_src_if

// ### design/ext_edge_detect.sv
// Purpose: edge or level detector with request latch for one external group
// Assumes: trig is already synchronised and nanded
// Notes: changing the sensitivity discards a pending edge
`timescale 1ns/1ps
`include "irq_ctrl_params.svh"
module ext_edge_detect (
  // clock and reset
  input logic clk,
  input logic rst,
  // sensitivity of the group
  input irq_ctrl_pkg::sens_t sens,
  // source link
  irq_src_if.latch src
);
  import irq_ctrl_pkg::*;
  logic prev_reg; // trig one cycle ago
  sens_t sensPrev_reg; // sensitivity one cycle ago
  logic pend_reg; // edge latch
  logic rise; // rising edge seen
  logic fall; // falling edge seen
  logic edgeHit; // edge of the selected kind

  assign rise = src.trig & ~prev_reg;
  assign fall = ~src.trig & prev_reg;

  // pick the edge that the sensitivity asks for, applied to the nand output
  always_comb begin
    unique case (sens)
      `SENS_RISE: edgeHit = rise;
      `SENS_FALL: edgeHit = fall;
      `SENS_BOTH: edgeHit = rise | fall;
      default: edgeHit = fall; // falling edge plus low level
    endcase
  end

  // history of trig and sensitivity
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 1'b0; // idle nand output is low, so no false edge after reset
      sensPrev_reg <= `SENS_FALL_LOW;
    end else begin
      prev_reg <= src.trig;
      sensPrev_reg <= sens;
    end
  end

  // request latch, a new edge wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (src.en && edgeHit) begin
      pend_reg <= 1'b1;
    end else if (src.clr || sens != sensPrev_reg) begin
      pend_reg <= 1'b0;
    end
  end

  assign src.pend = pend_reg;
  assign src.req = src.en & (pend_reg | (sens == `SENS_FALL_LOW && !src.trig));
endmodule : ext_edge_detect

// ### design/periph_req_latch.sv
// Purpose: request latch for one peripheral status flag
// Assumes: flag and clear come from logic on the same clock
// Notes: the latch fills on the flag's rising edge
`timescale 1ns/1ps
module periph_req_latch (
  // clock and reset
  input logic clk,
  input logic rst,
  // source link
  irq_src_if.latch src
);
  logic prev_reg; // flag one cycle ago
  logic pend_reg; // pending request

  // flag history
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= src.trig;
    end
  end

  // latched while not enabled, dropped by the clearing sequence, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (src.trig && !prev_reg) begin
      pend_reg <= 1'b1;
    end else if (src.clr) begin
      pend_reg <= 1'b0;
    end
  end

  assign src.pend = pend_reg;
  assign src.req = pend_reg & src.en;
endmodule : periph_req_latch

// ### design/cpu_interrupt_controller.sv
// Purpose: interrupt sequencer, arbiter and wake logic of an 8-bit core
// Assumes: 40 MHz clk, sync active-high rst, stack accepts one byte a cycle
// Notes: peripheral order on the periph ports is vectors 2,3,4,6,11
// What this block does
// - maskable requests plus one unmaskable trap
// - maskable served only while mask clear
// - reset disables maskables, vectors fffe, wakes
// - entry waits for instruction end
// - entry pushes program counter, index, accumulator, flags
// - entry sets the global mask bit
// - program counter loads the selected vector
// - return pops context, mask restored from stacked flags
// - fixed priority reset, trap, ascending vectors
// - trap ignores mask, vectors fffc
// - all wake wait; halt only halt-capable
// - external edge latch cleared on entry
// - group pins nanded before detector
// - sensitivity applies to nanded output
// - peripheral request needs enable, else pending
// - clearing sequence discards pending latch
// - external groups vectors 0 and 1
// - clock monitor 2, serial port 3
// - timers 4 and 6, two-wire 11
// - clock monitor needs flag and enable
`timescale 1ns/1ps
`include "irq_ctrl_params.svh"
module cpu_interrupt_controller #(
  parameter int EXT_WIDTH = 8 // pins per external group
) (
  // clock and reset
  input logic clk,
  input logic rst,
  // core instruction events
  input logic instrBoundary, // last cycle of an instruction
  input logic trapExec, // trap instruction at this boundary
  input logic returnExec, // return_from_handler_instruction at this boundary
  input logic maskSet, // software sets the mask
  input logic maskClr, // software clears the mask
  input logic waitEnter, // wait instruction executed
  input logic haltEnter, // halt instruction executed
  // core context
  input logic [15:0] programCounter,
  input logic [7:0] indexReg,
  input logic [7:0] accumulator,
  input logic [7:0] conditionCodeIn,
  // stack
  output logic pushValid_reg,
  output logic [7:0] pushByte_reg,
  output logic popReq_reg,
  input logic popValid,
  input logic [7:0] popByte,
  // external pin groups
  input logic [EXT_WIDTH-1:0] externalGroupZero,
  input logic [EXT_WIDTH-1:0] externalGroupZeroEn,
  input irq_ctrl_pkg::sens_t externalGroupZeroSens,
  input logic [EXT_WIDTH-1:0] externalGroupOne,
  input logic [EXT_WIDTH-1:0] externalGroupOneEn,
  input irq_ctrl_pkg::sens_t externalGroupOneSens,
  // peripheral flags, enables and clearing sequences
  input logic [4:0] periphFlag,
  input logic [4:0] periphEnable,
  input logic [4:0] periphClear,
  // core control
  output logic cpuHold_reg,
  output logic vectorLoad_reg,
  output logic [15:0] vectorAddr_reg,
  output logic [3:0] vectorNum_reg,
  output logic maskBit_reg,
  output logic restoreValid_reg,
  output logic [15:0] restoredPc_reg,
  output logic [7:0] restoredX_reg,
  output logic [7:0] restoredA_reg,
  output logic [7:0] restoredFlags_reg,
  // power
  output irq_ctrl_pkg::power_t power_reg,
  output logic wake_reg
);
  import irq_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  ctrl_state_t state_reg; // sequencer state
  logic [2:0] cnt_reg; // context byte counter
  logic [15:0] ctxPc_reg; // saved program counter
  logic [7:0] ctxX_reg; // saved index
  logic [7:0] ctxA_reg; // saved accumulator
  logic [7:0] ctxFlags_reg; // saved flags with mask bit
  logic [15:0] selAddr_reg; // vector chosen at acceptance
  logic [3:0] selNum_reg; // vector number chosen
  logic [EXT_WIDTH-1:0] pin0Meta_reg; // first sync stage, group 0
  logic [EXT_WIDTH-1:0] pin0Sync_reg; // second sync stage, group 0
  logic [EXT_WIDTH-1:0] pin1Meta_reg; // first sync stage, group 1
  logic [EXT_WIDTH-1:0] pin1Sync_reg; // second sync stage, group 1
  logic [`NUM_VECTORS-1:0] reqVec; // requests by vector number
  logic [`NUM_VECTORS-1:0] reqUsed; // requests on used slots
  logic [3:0] pickNum; // winning vector number
  logic anyReq; // some maskable request present
  logic accept; // interrupt taken this cycle
  logic [1:0] extClr; // external latch clears
  logic [4:0] periphReq; // peripheral gated requests
  logic [15:0] pickAddr; // address of winning vector
  logic [15:0] popPc_next; // program counter being assembled

  irq_src_if ext0If ();
  irq_src_if ext1If ();

  ////////////////////////////////////////////////////////////////////////////
  // external groups

  // two-stage synchronisers for the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      pin0Meta_reg <= '1;
      pin0Sync_reg <= '1;
      pin1Meta_reg <= '1;
      pin1Sync_reg <= '1;
    end else begin
      pin0Meta_reg <= externalGroupZero;
      pin0Sync_reg <= pin0Meta_reg;
      pin1Meta_reg <= externalGroupOne;
      pin1Sync_reg <= pin1Meta_reg;
    end
  end

  // enabled pins nanded, a low enabled pin holds the output high
  assign ext0If.trig = ~&(pin0Sync_reg | ~externalGroupZeroEn);
  assign ext1If.trig = ~&(pin1Sync_reg | ~externalGroupOneEn);
  assign ext0If.en = |externalGroupZeroEn;
  assign ext1If.en = |externalGroupOneEn;
  assign ext0If.clr = extClr[0];
  assign ext1If.clr = extClr[1];

  // latch cleared when its own vector is taken
  assign extClr[0] = accept && !trapExec && pickNum == 4'h0;
  assign extClr[1] = accept && !trapExec && pickNum == 4'h1;

  ext_edge_detect ext0Det (
    .clk(clk),
    .rst(rst),
    .sens(externalGroupZeroSens),
    .src(ext0If.latch)
  );

  ext_edge_detect ext1Det (
    .clk(clk),
    .rst(rst),
    .sens(externalGroupOneSens),
    .src(ext1If.latch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // peripheral latches

  generate
    for (genvar g = 0; g < 5; g++) begin : gPeriph
      irq_src_if pIf ();
      assign pIf.trig = periphFlag[g];
      assign pIf.en = periphEnable[g];
      assign pIf.clr = periphClear[g];
      assign periphReq[g] = pIf.req;
      periph_req_latch latch (
        .clk(clk),
        .rst(rst),
        .src(pIf.latch)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // arbitration

  // requests placed on their vector numbers, unused slots tied off
  always_comb begin
    reqVec = '0;
    reqVec[0] = ext0If.req;
    reqVec[1] = ext1If.req;
    reqVec[2] = periphReq[0];
    reqVec[3] = periphReq[1];
    reqVec[4] = periphReq[2];
    reqVec[6] = periphReq[3];
    reqVec[11] = periphReq[4];
  end

  assign reqUsed = reqVec & `VEC_USED_MASK;
  assign anyReq = |reqUsed;

  // lowest number wins
  always_comb begin
    pickNum = 4'h0;
    for (int i = `NUM_VECTORS - 1; i >= 0; i--) begin
      if (reqUsed[i]) begin
        pickNum = 4'(i);
      end
    end
  end

  assign pickAddr = `VEC_BASE - {11'h000, pickNum, 1'b0};

  // taken only at an instruction end, trap regardless of the mask
  assign accept = state_reg == ST_IDLE && instrBoundary && power_reg == LP_RUN &&
                  (trapExec || (anyReq && !maskBit_reg));

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  // entry, vector load and return steps
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_VEC;
      cnt_reg <= 3'h0;
      cpuHold_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 3'h0;
          if (accept) begin
            state_reg <= ST_PUSH;
            cpuHold_reg <= 1'b1;
          end else if (instrBoundary && returnExec) begin
            state_reg <= ST_POP;
            cpuHold_reg <= 1'b1;
          end
        end
        ST_PUSH: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == `CTX_LAST) begin
            state_reg <= ST_VEC;
          end
        end
        ST_VEC: begin
          state_reg <= ST_IDLE;
          cpuHold_reg <= 1'b0;
        end
        ST_POP: begin
          if (popValid) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == `CTX_LAST) begin
              state_reg <= ST_IDLE;
              cpuHold_reg <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          cpuHold_reg <= 1'b0;
        end
      endcase
    end
  end

  // context capture and chosen vector
  always_ff @(posedge clk) begin
    if (rst) begin
      ctxPc_reg <= 16'h0000;
      ctxX_reg <= 8'h00;
      ctxA_reg <= 8'h00;
      ctxFlags_reg <= 8'h00;
      selAddr_reg <= `VEC_RESET;
      selNum_reg <= 4'h0;
    end else if (accept) begin
      ctxPc_reg <= programCounter;
      ctxX_reg <= indexReg;
      ctxA_reg <= accumulator;
      ctxFlags_reg <= conditionCodeIn;
      ctxFlags_reg[`MASK_BIT_POS] <= maskBit_reg;
      selAddr_reg <= trapExec ? `VEC_TRAP : pickAddr;
      selNum_reg <= trapExec ? 4'h0 : pickNum;
    end
  end

  // stack pushes: pc low, pc high, index, accumulator, flags
  always_ff @(posedge clk) begin
    if (rst) begin
      pushValid_reg <= 1'b0;
      pushByte_reg <= 8'h00;
    end else if (accept) begin
      pushValid_reg <= 1'b1;
      pushByte_reg <= programCounter[7:0];
    end else if (state_reg == ST_PUSH) begin
      unique case (cnt_reg)
        3'h0: pushByte_reg <= ctxPc_reg[15:8];
        3'h1: pushByte_reg <= ctxX_reg;
        3'h2: pushByte_reg <= ctxA_reg;
        3'h3: pushByte_reg <= ctxFlags_reg;
        default: pushValid_reg <= 1'b0;
      endcase
    end
  end

  // vector load pulse after the context is saved
  always_ff @(posedge clk) begin
    if (rst) begin
      vectorLoad_reg <= 1'b0;
      vectorAddr_reg <= `VEC_RESET;
      vectorNum_reg <= 4'h0;
    end else begin
      vectorLoad_reg <= state_reg == ST_VEC;
      if (state_reg == ST_VEC) begin
        vectorAddr_reg <= selAddr_reg;
        vectorNum_reg <= selNum_reg;
      end
    end
  end

  // pops: flags, accumulator, index, pc high, pc low
  assign popPc_next = {restoredPc_reg[15:8], popByte};

  always_ff @(posedge clk) begin
    if (rst) begin
      popReq_reg <= 1'b0;
      restoreValid_reg <= 1'b0;
      restoredPc_reg <= 16'h0000;
      restoredX_reg <= 8'h00;
      restoredA_reg <= 8'h00;
      restoredFlags_reg <= 8'h00;
    end else begin
      restoreValid_reg <= 1'b0;
      popReq_reg <= (state_reg == ST_IDLE && !accept && instrBoundary && returnExec) ||
                    (state_reg == ST_POP && !(popValid && cnt_reg == `CTX_LAST));
      if (state_reg == ST_POP && popValid) begin
        unique case (cnt_reg)
          3'h0: restoredFlags_reg <= popByte;
          3'h1: restoredA_reg <= popByte;
          3'h2: restoredX_reg <= popByte;
          3'h3: restoredPc_reg[15:8] <= popByte;
          default: begin
            restoredPc_reg <= popPc_next;
            restoreValid_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global mask bit

  always_ff @(posedge clk) begin
    if (rst) begin
      maskBit_reg <= 1'b1;
    end else if (accept) begin
      maskBit_reg <= 1'b1;
    end else if (state_reg == ST_POP && popValid && cnt_reg == 3'h0) begin
      maskBit_reg <= popByte[`MASK_BIT_POS];
    end else if (waitEnter || haltEnter || maskClr) begin
      maskBit_reg <= 1'b0;
    end else if (maskSet) begin
      maskBit_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low power and wake

  // wait wakes on any source, halt only on halt-capable ones
  always_ff @(posedge clk) begin
    if (rst) begin
      power_reg <= LP_RUN;
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= 1'b0;
      unique case (power_reg)
        LP_WAIT: begin
          if (anyReq) begin
            power_reg <= LP_RUN;
            wake_reg <= 1'b1;
          end
        end
        LP_HALT: begin
          if (|(reqUsed & `HALT_WAKE_MASK)) begin
            power_reg <= LP_RUN;
            wake_reg <= 1'b1;
          end
        end
        LP_RUN: begin
          if (haltEnter) begin
            power_reg <= LP_HALT;
          end else if (waitEnter) begin
            power_reg <= LP_WAIT;
          end
        end
        default: power_reg <= LP_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  reset_vector_a: assert property (@(posedge clk) $fell(rst) |=> vectorLoad_reg && vectorAddr_reg == 16'hfffe && maskBit_reg) else $error("reset vector not fetched");
  entry_push_a: assert property (@(posedge clk) disable iff (rst) accept |=> pushValid_reg [*5] ##1 !pushValid_reg) else $error("context push not five bytes");
  entry_mask_a: assert property (@(posedge clk) disable iff (rst) accept |=> maskBit_reg) else $error("mask not set on entry");
  hold_start_a: assert property (@(posedge clk) disable iff (rst) $rose(cpuHold_reg) |-> $past(instrBoundary)) else $error("hold began mid instruction");
  vector_load_a: assert property (@(posedge clk) disable iff (rst) accept |-> ##7 vectorLoad_reg) else $error("vector not loaded after push");
  trap_vector_a: assert property (@(posedge clk) disable iff (rst) (accept && trapExec) |-> ##7 vectorAddr_reg == 16'hfffc) else $error("trap vector wrong");
  masked_block_a: assert property (@(posedge clk) disable iff (rst) (state_reg == ST_IDLE && maskBit_reg && !trapExec) |=> !pushValid_reg) else $error("masked request entered");
  return_pop_a: assert property (@(posedge clk) disable iff (rst) (state_reg == ST_IDLE && instrBoundary && returnExec && !accept) |-> ##[5:40] restoreValid_reg) else $error("return not completed");
  halt_wake_a: assert property (@(posedge clk) disable iff (rst) (power_reg == LP_HALT && (reqUsed & 14'h0003) == 14'h0000) |=> !wake_reg) else $error("halt woken by wrong source");
endmodule : cpu_interrupt_controller

// ### tb/stack_model.sv
// Purpose: byte stack behind the push and pop ports of the controller
// Assumes: one byte pushed per cycle, pops wanted while popReq_reg is high
// Notes: answers every other cycle; idle data toggles so stale bytes never pass
`timescale 1ns/1ps
module stack_model (
  // clock and reset
  input logic clk,
  input logic rst,
  // push side
  input logic pushValid_reg,
  input logic [7:0] pushByte_reg,
  // pop side
  input logic popReq_reg,
  output logic popValid,
  output logic [7:0] popByte
);
  logic [7:0] mem_reg [0:15]; // stored bytes
  logic [3:0] sp_reg; // next free slot
  ////////////////////////////////////////////////////////////////
  // push stores, pop returns last in first out
  always_ff @(posedge clk) begin
    if (rst) begin
      sp_reg <= 4'h0;
      popValid <= 1'b0;
      popByte <= 8'h00;
    end else if (pushValid_reg) begin
      mem_reg[sp_reg] <= pushByte_reg;
      sp_reg <= sp_reg + 4'h1;
    end else if (popReq_reg && !popValid) begin
      popValid <= 1'b1;
      popByte <= mem_reg[sp_reg - 4'h1];
      sp_reg <= sp_reg - 4'h1;
    end else begin
      popValid <= 1'b0;
      popByte <= ~popByte; // no stale data between answers
    end
  end
endmodule : stack_model

// ### tb/cpu_interrupt_controller_bench.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: 40 MHz clock, stack partner in stack_model
// Notes: source rows in a table, then masking, clearing, nand and power cases
`timescale 1ns/1ps
module cpu_interrupt_controller_bench;
  import irq_ctrl_pkg::*;
  typedef struct packed {logic [3:0] num; logic [15:0] addr;} row_t;
  // expected vector of each source, order ext0, ext1, then periph bits 0..4
  row_t rows [7] = '{'{4'h0, 16'hfffa}, '{4'h1, 16'hfff8}, '{4'h2, 16'hfff6},
    '{4'h3, 16'hfff4}, '{4'h4, 16'hfff2}, '{4'h6, 16'hffee}, '{4'hb, 16'hffe4}};
  logic clk = 1'b0, rst = 1'b1;
  logic instrBoundary = 1'b0, trapExec = 1'b0, returnExec = 1'b0, maskSet = 1'b0, maskClr = 1'b0;
  logic waitEnter = 1'b0, haltEnter = 1'b0;
  logic [15:0] programCounter = 16'h1234;
  logic [7:0] indexReg = 8'h56, accumulator = 8'h78, conditionCodeIn = 8'h00;
  logic [7:0] externalGroupZero = 8'hff, externalGroupZeroEn = 8'h01;
  logic [7:0] externalGroupOne = 8'hff, externalGroupOneEn = 8'h01;
  sens_t externalGroupZeroSens = 2'h1, externalGroupOneSens = 2'h1;
  logic [4:0] periphFlag = 5'h00, periphEnable = 5'h1f, periphClear = 5'h00;
  logic pushValid_reg, popReq_reg, popValid, cpuHold_reg, vectorLoad_reg, maskBit_reg, restoreValid_reg, wake_reg;
  logic [7:0] pushByte_reg, popByte, restoredX_reg, restoredA_reg, restoredFlags_reg;
  logic [15:0] vectorAddr_reg, restoredPc_reg;
  logic [3:0] vectorNum_reg;
  power_t power_reg;
  int nErrors = 0, checksDone = 0, r, k;
  ////////////////////////////////////////////////////////////////
  cpu_interrupt_controller #(.EXT_WIDTH(8)) i_dut (.clk, .rst, .instrBoundary, .trapExec, .returnExec,
    .maskSet, .maskClr, .waitEnter, .haltEnter, .programCounter, .indexReg, .accumulator, .conditionCodeIn,
    .pushValid_reg, .pushByte_reg, .popReq_reg, .popValid, .popByte, .externalGroupZero, .externalGroupZeroEn,
    .externalGroupZeroSens, .externalGroupOne, .externalGroupOneEn, .externalGroupOneSens, .periphFlag,
    .periphEnable, .periphClear, .cpuHold_reg, .vectorLoad_reg, .vectorAddr_reg, .vectorNum_reg, .maskBit_reg,
    .restoreValid_reg, .restoredPc_reg, .restoredX_reg, .restoredA_reg, .restoredFlags_reg, .power_reg, .wake_reg);
  stack_model i_stack (.clk, .rst, .pushValid_reg, .pushByte_reg, .popReq_reg, .popValid, .popByte);
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic testDone();
    if (nErrors == 0 && checksDone > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : testDone
  // one compare for every value kind
  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
    checksDone++;
    if (got !== expv) begin
      $display("CHECK FAILED %s expected %h seen %h", what, expv, got);
      nErrors++;
    end
  endtask : chk
  // a bound that runs out ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      nErrors++;
      testDone();
    end
  endtask : bound
  // one instruction boundary, accept edge is the second
  task automatic bnd(input logic t, input logic i);
    @(posedge clk);
    instrBoundary <= 1'b1;
    trapExec <= t;
    returnExec <= i;
    @(posedge clk);
    instrBoundary <= 1'b0;
    trapExec <= 1'b0;
    returnExec <= 1'b0;
    #1;
  endtask : bnd
  // boundary that must be refused
  task automatic noEntry();
    bnd(1'b0, 1'b0);
    chk("hold", 1'b0, cpuHold_reg);
  endtask : noEntry
  // accepted entry up to the vector load
  task automatic enter(input logic t, input row_t x);
    bnd(t, 1'b0);
    chk("mask", 1'b1, maskBit_reg);
    for (k = 0; k < 12 && vectorLoad_reg !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    bound(k, 12);
    chk("addr", x.addr, vectorAddr_reg);
    chk("num", x.num, vectorNum_reg);
  endtask : enter
  // return and restored context
  task automatic ret(input logic [7:0] flags);
    bnd(1'b0, 1'b1);
    for (k = 0; k < 30 && restoreValid_reg !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    bound(k, 30);
    chk("pc", 16'h1234, restoredPc_reg);
    chk("x", 8'h56, restoredX_reg);
    chk("a", 8'h78, restoredA_reg);
    chk("flags", flags, restoredFlags_reg);
    chk("mask", flags[3], maskBit_reg);
  endtask : ret
  // software clearing sequence of one flag
  task automatic pulseClear(input int i);
    @(posedge clk);
    periphFlag[i] <= 1'b0;
    periphClear[i] <= 1'b1;
    @(posedge clk);
    periphClear[i] <= 1'b0;
  endtask : pulseClear
  // wait for the core to run again
  task automatic waitRun();
    for (k = 0; k < 12 && power_reg !== LP_RUN; k++) begin
      @(posedge clk);
      #1;
    end
    bound(k, 12);
    chk("wake", 1'b1, wake_reg);
  endtask : waitRun
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("hold", 1'b1, cpuHold_reg);
    chk("mask", 1'b1, maskBit_reg);
    @(posedge clk);
    #1;
    chk("vload", 1'b1, vectorLoad_reg);
    chk("addr", 16'hfffe, vectorAddr_reg);
    @(posedge clk);
    maskClr <= 1'b1;
    @(posedge clk);
    maskClr <= 1'b0;
    // every source in turn
    for (r = 0; r < 7; r++) begin
      @(posedge clk);
      if (r == 0) externalGroupZero <= 8'hfe;
      else if (r == 1) externalGroupOne <= 8'hfe;
      else periphFlag[r-2] <= 1'b1;
      repeat (4) @(posedge clk);
      enter(1'b0, rows[r]);
      @(posedge clk);
      externalGroupZero <= 8'hff;
      externalGroupOne <= 8'hff;
      if (r > 1) pulseClear(r - 2);
      ret(8'h00);
    end
    noEntry();
    // masked pair, trap first, then ascending numbers
    @(posedge clk);
    maskSet <= 1'b1;
    conditionCodeIn <= 8'h08;
    periphFlag <= 5'h0a;
    @(posedge clk);
    maskSet <= 1'b0;
    repeat (2) @(posedge clk);
    noEntry();
    enter(1'b1, '{4'h0, 16'hfffc});
    ret(8'h08);
    @(posedge clk);
    maskClr <= 1'b1;
    conditionCodeIn <= 8'h00;
    @(posedge clk);
    maskClr <= 1'b0;
    enter(1'b0, rows[3]);
    pulseClear(1);
    ret(8'h00);
    enter(1'b0, rows[5]);
    pulseClear(3);
    ret(8'h00);
    // pending without enable, then discarded by clearing
    @(posedge clk);
    periphEnable <= 5'h1e;
    periphFlag <= 5'h01;
    repeat (2) @(posedge clk);
    noEntry();
    @(posedge clk);
    periphEnable <= 5'h1f;
    enter(1'b0, rows[2]);
    pulseClear(0);
    ret(8'h00);
    @(posedge clk);
    periphEnable <= 5'h1e;
    periphFlag <= 5'h01;
    pulseClear(0);
    @(posedge clk);
    periphEnable <= 5'h1f;
    noEntry();
    // low pin of a nand group masks the other pin
    @(posedge clk);
    externalGroupOneEn <= 8'h03;
    externalGroupOne <= 8'hfd;
    repeat (5) @(posedge clk);
    externalGroupOneSens <= 2'h2;
    @(posedge clk);
    externalGroupOneSens <= 2'h1;
    @(posedge clk);
    externalGroupOne <= 8'hfc;
    repeat (5) @(posedge clk);
    noEntry();
    // wake from wait by timer B, halt ignores two-wire
    @(posedge clk);
    waitEnter <= 1'b1;
    @(posedge clk);
    waitEnter <= 1'b0;
    periphFlag <= 5'h08;
    #1;
    chk("power", LP_WAIT, power_reg);
    waitRun();
    pulseClear(3);
    @(posedge clk);
    haltEnter <= 1'b1;
    @(posedge clk);
    haltEnter <= 1'b0;
    periphFlag <= 5'h10;
    repeat (6) @(posedge clk);
    #1;
    chk("power", LP_HALT, power_reg);
    @(posedge clk);
    externalGroupZero <= 8'hfe;
    waitRun();
    chk("power", LP_RUN, power_reg);
    // reset in mid-run wakes from halt, masks and fetches its vector
    @(posedge clk);
    externalGroupZero <= 8'hff;
    externalGroupZeroSens <= 2'h2;
    @(posedge clk);
    externalGroupZeroSens <= 2'h1;
    haltEnter <= 1'b1;
    @(posedge clk);
    haltEnter <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("power", LP_HALT, power_reg);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("power", LP_RUN, power_reg);
    chk("mask", 1'b1, maskBit_reg);
    @(posedge clk);
    #1;
    chk("vload", 1'b1, vectorLoad_reg);
    chk("addr", 16'hfffe, vectorAddr_reg);
    testDone();
  end
endmodule : cpu_interrupt_controller_bench
